// File: src/fmbc_consts.vh
`ifndef FMBC_CONSTS_VH
`define FMBC_CONSTS_VH
// register offsets
`define FMBC_REG_CTRL      4'h0
`define FMBC_REG_WARM      4'h1
`define FMBC_REG_STATUS    4'h2
`define FMBC_REG_HIST      4'h3
`define FMBC_REG_WDOG      4'h4
// control register fields
`define FMBC_CTRL_FB_EN    0
`define FMBC_CTRL_SPI      1
`define FMBC_CTRL_PAR      2
`define FMBC_CTRL_SYNC     3
`define FMBC_CTRL_WDOG_EN  4
`define FMBC_CTRL_WIDTH_LO 5
`define FMBC_CTRL_WIDTH_HI 6
// reset values
`define FMBC_GOLDEN_ADDR   32'h0000_0000
`define FMBC_RS_GOLDEN     2'h0
`define FMBC_WIDTH_X1      2'h0
`define FMBC_CTRL_RESET    32'h0000_0000
// timing
`define FMBC_CLEAR_NS      1000
`define FMBC_CLK_NS        10
`define FMBC_CLEAR_CYCLES  ((`FMBC_CLEAR_NS + `FMBC_CLK_NS - 1) / `FMBC_CLK_NS)
`define FMBC_WDOG_DEFAULT  32'h0000_ffff
`endif

// File: src/fmbc_error_collect.v
`timescale 1ns/10ps
`include "fmbc_consts.vh"
module fmbc_error_collect (
    input  wire       idcode_err_in,
    input  wire       crc_err_in,
    input  wire       wdog_err_in,
    input  wire       wrap_err_in,
    input  wire       par_mode_in,
    input  wire       active_in,
    output wire       any_err_out,
    output wire [3:0] cause_out
);
    assign cause_out   = {wrap_err_in & par_mode_in, wdog_err_in, crc_err_in, idcode_err_in};
    assign any_err_out = active_in & (|cause_out);
endmodule

// File: src/fmbc_watchdog.v
`timescale 1ns/10ps
`include "fmbc_consts.vh"
module fmbc_watchdog #(
    parameter WIDTH = 32
) (
    input  wire             mclk_in,
    input  wire             rstn_in,
    input  wire             start_in,
    input  wire             stop_in,
    input  wire             enable_in,
    input  wire [WIDTH-1:0] load_in,
    output reg              expire_out
);
    reg [WIDTH-1:0] count;
    reg             run;
    always @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            count      <= {WIDTH{1'b0}};
            run        <= 1'b0;
            expire_out <= 1'b0;
        end else begin
            expire_out <= 1'b0;
            if (start_in) begin
                count <= load_in;
                run   <= enable_in;
            end else if (stop_in || !enable_in) begin
                run <= 1'b0;
            end else if (run) begin
                if (count == {WIDTH{1'b0}}) begin
                    expire_out <= 1'b1;
                    run        <= 1'b0;
                end else begin
                    count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule

// File: src/fmbc_top.v
// Behaviour
// - fallback reset spares boot logic, address, history
// - fallback drops init/done, clears, restarts at 0
// - reloaded image may rewrite warm-start address
// - idcode, crc, watchdog errors, and wraparound errors in parallel mode only, trigger fallback
// - fallback enabled by bitstream option
// - reprogram command ignored during fallback load
// - watchdog disabled during fallback load
// - failed fallback halts with init/done low
// - works in every master mode
// - power up loads golden image from 0
// - failing upper image falls back to golden
// - spi fallback reads at x1 width
// - parallel fallback uses asynchronous reads
// - reprogram clears, restarts at warm-start address
// - unset warm-start address becomes zero
// - watchdog counts from start, stops at startup end
`timescale 1ns/10ps
`include "fmbc_consts.vh"
module fmbc_top #(
    parameter ADDR_W       = 32,
    parameter CLEAR_CYCLES = `FMBC_CLEAR_CYCLES
) (
    input  wire              mclk_in,
    input  wire              rstn_in,
    input  wire [3:0]        reg_addr_in,
    input  wire [31:0]       reg_wdata_in,
    input  wire              reg_wr_in,
    input  wire              reg_rd_in,
    output reg  [31:0]       reg_rdata_out,
    input  wire              bs_start_in,
    input  wire              bs_warm_wr_in,
    input  wire [ADDR_W-1:0] bs_warm_data_in,
    input  wire              bs_reprogram_in,
    input  wire              bs_startup_done_in,
    input  wire              idcode_err_in,
    input  wire              crc_err_in,
    input  wire              wrap_err_in,
    output reg               load_req_out,
    output reg  [ADDR_W-1:0] load_addr_out,
    output reg  [1:0]        revision_select_pins_out,
    output reg               revision_select_pins_oe_out,
    output reg  [1:0]        bus_width_out,
    output reg               sync_read_out,
    output reg               config_reset_out,
    output reg               mem_clear_out,
    output reg               init_out,
    output reg               done_out
);
    localparam S_CLEAR   = 6'b000001;
    localparam S_LOAD    = 6'b000010;
    localparam S_LOADING = 6'b000100;
    localparam S_DONE    = 6'b001000;
    localparam S_HALT    = 6'b010000;
    localparam S_IDLE    = 6'b100000;

    reg [5:0]        state;
    reg [5:0]        next_state;
    reg [31:0]       ctrl;
    reg [31:0]       wdog_load;
    reg [ADDR_W-1:0] warm_start_address;
    reg              warm_written;
    reg              in_fallback;
    reg              next_in_fallback;
    reg              use_warm;
    reg              next_use_warm;
    reg [7:0]        boot_history_status;
    reg [31:0]       warm_word;
    reg [15:0]       clear_cnt;
    wire             any_err;
    wire [3:0]       cause;
    wire             wdog_expire;
    wire             fb_enable;
    wire             loading;
    wire             reprogram;
    wire             clear_done;

    assign fb_enable  = ctrl[`FMBC_CTRL_FB_EN];
    assign loading    = (state == S_LOADING);
    assign reprogram  = bs_reprogram_in & (state == S_DONE) & !in_fallback;
    assign clear_done = (clear_cnt == 16'h0000);

    fmbc_error_collect u_err (
        .idcode_err_in (idcode_err_in),
        .crc_err_in    (crc_err_in),
        .wdog_err_in   (wdog_expire),
        .wrap_err_in   (wrap_err_in),
        .par_mode_in   (ctrl[`FMBC_CTRL_PAR]),
        .active_in     (loading),
        .any_err_out   (any_err),
        .cause_out     (cause)
    );

    fmbc_watchdog #(
        .WIDTH (32)
    ) u_wdog (
        .mclk_in    (mclk_in),
        .rstn_in    (rstn_in),
        .start_in   (bs_start_in & loading),
        .stop_in    (bs_startup_done_in),
        .enable_in  (ctrl[`FMBC_CTRL_WDOG_EN] & !in_fallback),
        .load_in    (wdog_load),
        .expire_out (wdog_expire)
    );

    always @* begin
        next_state       = state;
        next_in_fallback = in_fallback;
        next_use_warm    = use_warm;
        case (state)
            S_CLEAR: begin
                if (clear_done) begin
                    next_state = S_LOAD;
                end
            end
            S_LOAD: begin
                next_state = S_LOADING;
            end
            S_LOADING: begin
                if (any_err) begin
                    if (in_fallback || !fb_enable) begin
                        next_state = S_HALT;
                    end else begin
                        next_state       = S_CLEAR;
                        next_in_fallback = 1'b1;
                        next_use_warm    = 1'b0;
                    end
                end else if (bs_startup_done_in) begin
                    next_state = S_DONE;
                end
            end
            S_DONE: begin
                if (reprogram) begin
                    next_state       = S_CLEAR;
                    next_in_fallback = 1'b0;
                    next_use_warm    = 1'b1;
                end
            end
            S_HALT: begin
                next_state = S_HALT;
            end
            S_IDLE: begin
                next_state = S_CLEAR;
            end
            default: begin
                next_state = S_CLEAR;
            end
        endcase
    end

    always @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state       <= S_CLEAR;
            in_fallback <= 1'b0;
            use_warm    <= 1'b0;
            clear_cnt   <= CLEAR_CYCLES[15:0];
        end else begin
            state       <= next_state;
            in_fallback <= next_in_fallback;
            use_warm    <= next_use_warm;
            if (next_state == S_CLEAR && state != S_CLEAR) begin
                clear_cnt <= CLEAR_CYCLES[15:0];
            end else if (state == S_CLEAR && !clear_done) begin
                clear_cnt <= clear_cnt - 16'h0001;
            end
        end
    end

    // warm-start address and history survive the fallback reset
    always @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            warm_start_address  <= `FMBC_GOLDEN_ADDR;
            warm_written        <= 1'b0;
            boot_history_status <= 8'h00;
        end else begin
            // only the bitstream counts as setting the address for the zero default
            if (reg_wr_in && reg_addr_in == `FMBC_REG_WARM) begin
                warm_start_address <= reg_wdata_in[ADDR_W-1:0];
            end else if (bs_warm_wr_in && loading) begin
                warm_start_address <= bs_warm_data_in;
                warm_written       <= 1'b1;
            end else if (state == S_LOADING && next_state == S_DONE && !warm_written) begin
                warm_start_address <= `FMBC_GOLDEN_ADDR;
            end
            if (state == S_LOAD) begin
                warm_written <= 1'b0;
            end
            if (state == S_LOADING && any_err) begin
                boot_history_status <= {in_fallback, 3'h0, cause};
            end
        end
    end

    // ctrl bits above 2 cleared by fallback reset, wdog_load kept; both kept by reprogram
    always @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ctrl      <= `FMBC_CTRL_RESET;
            wdog_load <= `FMBC_WDOG_DEFAULT;
        end else if (state == S_LOADING && any_err && !in_fallback && fb_enable) begin
            ctrl      <= `FMBC_CTRL_RESET | (ctrl & 32'h0000_0007);
        end else if (reg_wr_in && reg_addr_in == `FMBC_REG_CTRL) begin
            ctrl <= reg_wdata_in;
        end else if (reg_wr_in && reg_addr_in == `FMBC_REG_WDOG) begin
            wdog_load <= reg_wdata_in;
        end
    end

    always @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            load_req_out                <= 1'b0;
            load_addr_out               <= `FMBC_GOLDEN_ADDR;
            revision_select_pins_out    <= `FMBC_RS_GOLDEN;
            revision_select_pins_oe_out <= 1'b0;
            bus_width_out               <= `FMBC_WIDTH_X1;
            sync_read_out               <= 1'b0;
            config_reset_out            <= 1'b1;
            mem_clear_out               <= 1'b1;
            init_out                    <= 1'b0;
            done_out                    <= 1'b0;
        end else begin
            load_req_out     <= (state == S_LOAD);
            config_reset_out <= (next_state == S_CLEAR) && (state != S_CLEAR);
            mem_clear_out    <= (next_state == S_CLEAR);
            init_out         <= (next_state == S_LOADING) || (next_state == S_DONE);
            done_out         <= (next_state == S_DONE);
            if (state == S_LOAD) begin
                if (use_warm) begin
                    load_addr_out <= warm_start_address;
                end else begin
                    load_addr_out <= `FMBC_GOLDEN_ADDR;
                end
                revision_select_pins_oe_out <= in_fallback & !ctrl[`FMBC_CTRL_SPI];
                revision_select_pins_out    <= `FMBC_RS_GOLDEN;
                if (in_fallback && ctrl[`FMBC_CTRL_SPI]) begin
                    bus_width_out <= `FMBC_WIDTH_X1;
                end else begin
                    bus_width_out <= ctrl[`FMBC_CTRL_WIDTH_HI:`FMBC_CTRL_WIDTH_LO];
                end
                sync_read_out <= ctrl[`FMBC_CTRL_SYNC] & ctrl[`FMBC_CTRL_PAR]
                                 & !in_fallback;
            end
            if (next_state == S_HALT) begin
                init_out <= 1'b0;
                done_out <= 1'b0;
            end
        end
    end

    // zero-extended warm-start address for the read port
    always @* begin
        warm_word             = 32'h0000_0000;
        warm_word[ADDR_W-1:0] = warm_start_address;
    end

    always @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            reg_rdata_out <= 32'h0000_0000;
        end else if (reg_rd_in) begin
            case (reg_addr_in)
                `FMBC_REG_CTRL:   reg_rdata_out <= ctrl;
                `FMBC_REG_WARM:   reg_rdata_out <= warm_word;
                `FMBC_REG_STATUS: reg_rdata_out <= {26'h0, state};
                `FMBC_REG_HIST:   reg_rdata_out <= {24'h0, boot_history_status};
                `FMBC_REG_WDOG:   reg_rdata_out <= wdog_load;
                default:          reg_rdata_out <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata_out <= 32'h0000_0000;
        end
    end
endmodule

// File: testbench/fmbc_top_monitor.sv
`timescale 1ns/10ps
module fmbc_monitor #(
    parameter ADDR_W       = 32,
    parameter CLEAR_CYCLES = 100
) (
    input wire              mclk_in,
    input wire              rstn_in,
    input wire              bs_reprogram_in,
    input wire              bs_startup_done_in,
    input wire              idcode_err_in,
    input wire              crc_err_in,
    input wire              load_req_out,
    input wire [ADDR_W-1:0] load_addr_out,
    input wire [1:0]        revision_select_pins_out,
    input wire              revision_select_pins_oe_out,
    input wire              sync_read_out,
    input wire              config_reset_out,
    input wire              mem_clear_out,
    input wire              init_out,
    input wire              done_out
);
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!rstn_in);
    a_clear_pins_low: assert property (mem_clear_out |-> !init_out && !done_out)
        else $error("init or done high while clearing");
    a_clear_then_load: assert property ($fell(mem_clear_out) |-> ##[0:3] load_req_out)
        else $error("no load request after clearing");
    a_load_raises_init: assert property (load_req_out |-> ##[0:1] init_out)
        else $error("init low at load request");
    a_load_one_pulse: assert property (load_req_out |=> !load_req_out)
        else $error("load request longer than one cycle");
    a_reset_one_pulse: assert property (config_reset_out |=> !config_reset_out)
        else $error("configuration reset longer than one cycle");
    a_reset_with_clear: assert property (config_reset_out |-> mem_clear_out)
        else $error("configuration reset without memory clear");
    a_error_drops_init: assert property ((idcode_err_in || crc_err_in) && init_out && !done_out
        |-> ##[1:3] !init_out)
        else $error("load error did not restart configuration");
    a_golden_pins: assert property (load_req_out && revision_select_pins_oe_out
        |-> load_addr_out == '0 && revision_select_pins_out == 2'h0)
        else $error("fallback load not at golden address");
    a_fallback_async: assert property (load_req_out && revision_select_pins_oe_out
        |-> !sync_read_out)
        else $error("synchronous read during fallback");
    a_done_cause: assert property ($rose(done_out)
        |-> $past(bs_startup_done_in) || $past(bs_startup_done_in, 2))
        else $error("done without startup end");
    cover property (load_req_out && revision_select_pins_oe_out);
    cover property (bs_reprogram_in && done_out);
    cover property ($rose(done_out));
endmodule

bind fmbc_top fmbc_monitor #(.ADDR_W(ADDR_W), .CLEAR_CYCLES(CLEAR_CYCLES)) fmbc_monitor_i (
    .mclk_in, .rstn_in, .bs_reprogram_in, .bs_startup_done_in, .idcode_err_in, .crc_err_in,
    .load_req_out, .load_addr_out, .revision_select_pins_out, .revision_select_pins_oe_out,
    .sync_read_out, .config_reset_out, .mem_clear_out, .init_out, .done_out);

// File: testbench/fmbc_flash_model.sv
`timescale 1ns/10ps
module fmbc_flash_model (
    input  wire        mclk_in,
    input  wire        load_req_in,
    input  wire [31:0] load_addr_in,
    input  wire [7:0]  delay_in,
    output reg         start_out = 1'b0,
    output reg  [31:0] image_addr_out = 32'h0
);
    reg [7:0] wait_cnt = 8'h0;
    // image header reached after the access delay
    always @(posedge mclk_in) begin
        start_out <= (wait_cnt == 8'h1);
        if (load_req_in) begin
            wait_cnt <= delay_in;
            image_addr_out <= load_addr_in;
        end else if (wait_cnt != 8'h0) begin
            wait_cnt <= wait_cnt - 8'h1;
        end
    end
endmodule

// File: testbench/test_fmbc_top.sv
`timescale 1ns/10ps
`include "fmbc_consts.vh"
module test_fmbc_top;
    reg         mclk_in = 1'b0;
    reg         rstn_in = 1'b0;
    reg  [3:0]  ra = 4'h0;
    reg  [31:0] wd = 32'h0;
    reg         we = 1'b0;
    reg         re = 1'b0;
    reg  [7:0]  ev = 8'h0;
    reg  [31:0] warm_data = 32'h0;
    reg  [7:0]  delay = 8'h1;
    reg  [31:0] seed = 32'h43;
    reg  [31:0] m_warm = 32'h0;
    reg  [31:0] got = 32'h0;
    reg         seen = 1'b0;
    wire [31:0] rdata;
    wire [31:0] load_addr;
    wire [31:0] img_addr;
    wire [1:0]  rs;
    wire [1:0]  width;
    wire        load_req, rs_oe, sync_rd, init, done, bs_start;
    integer     num_errors = 0;
    integer     n_checks = 0;
    always #5 mclk_in = ~mclk_in;
    fmbc_top #(.CLEAR_CYCLES(4)) fmbc_top_i (
        .mclk_in(mclk_in), .rstn_in(rstn_in), .reg_addr_in(ra), .reg_wdata_in(wd),
        .reg_wr_in(we), .reg_rd_in(re), .reg_rdata_out(rdata), .bs_start_in(bs_start),
        .bs_warm_wr_in(ev[4]), .bs_warm_data_in(warm_data), .bs_reprogram_in(ev[5]),
        .bs_startup_done_in(ev[6]), .idcode_err_in(ev[0]), .crc_err_in(ev[1]),
        .wrap_err_in(ev[3]), .load_req_out(load_req), .load_addr_out(load_addr),
        .revision_select_pins_out(rs), .revision_select_pins_oe_out(rs_oe),
        .bus_width_out(width), .sync_read_out(sync_rd), .config_reset_out(),
        .mem_clear_out(), .init_out(init), .done_out(done));
    fmbc_flash_model fmbc_flash_model_i (.mclk_in(mclk_in), .load_req_in(load_req),
        .load_addr_in(load_addr), .delay_in(delay), .start_out(bs_start),
        .image_addr_out(img_addr));
    function automatic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task chk(input string name, input logic [31:0] exp, input logic [31:0] val);
        n_checks++;
        if (val !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, val);
        end
    endtask
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk_in);
        ra <= a;
        wd <= d;
        we <= 1'b1;
        @(posedge mclk_in);
        we <= 1'b0;
    endtask
    task rd(input logic [3:0] a);
        @(posedge mclk_in);
        ra <= a;
        re <= 1'b1;
        @(posedge mclk_in);
        re <= 1'b0;
        #1 got = rdata;
    endtask
    task pulse(input int k);
        @(posedge mclk_in);
        ev <= 8'h1 << k;
        @(posedge mclk_in);
        ev <= 8'h0;
    endtask
    task wait_load(input int n);
        seen = 1'b0;
        repeat (n) begin
            @(posedge mclk_in);
            #1 seen = (load_req === 1'b1);
            if (seen) break;
        end
    endtask
    task boot;
        @(posedge mclk_in);
        rstn_in <= 1'b0;
        repeat (10) @(posedge mclk_in);
        rstn_in <= 1'b1;
        wait_load(200);
        chk("power-up load", 32'h1, {31'h0, seen});
        chk("power-up address", 32'h0, load_addr);
    endtask
    task summarize;
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        repeat (30000) @(posedge mclk_in);
        num_errors++;
        summarize();
    end
    initial begin
        boot();
        m_warm = (rnd() & 32'h00ff_fff0) | 32'h100;
        wr(`FMBC_REG_CTRL, 32'h43);
        warm_data <= m_warm;
        pulse(4);
        pulse(6);
        @(posedge mclk_in);
        #1 chk("done", 32'h1, {31'h0, done});
        pulse(5);
        wait_load(200);
        chk("jump address", m_warm, load_addr);
        pulse(1);
        chk("flash image", m_warm, img_addr);
        wait_load(200);
        chk("fallback address", 32'h0, load_addr);
        chk("fallback width", 32'h0, {30'h0, width});
        chk("spi pins undriven", 32'h0, {31'h0, rs_oe});
        rd(`FMBC_REG_WARM);
        chk("kept warm address", m_warm, got);
        rd(`FMBC_REG_HIST);
        chk("history", 32'h02, got);
        m_warm = rnd() & 32'h00ff_fff0;
        warm_data <= m_warm;
        pulse(4);
        pulse(6);
        pulse(5);
        wait_load(40);
        chk("reprogram ignored", 32'h0, {31'h0, seen});
        rd(`FMBC_REG_WARM);
        chk("new warm address", m_warm, got);
        $display("jump and fallback test done");
        for (int k = 0; k < 4; k++) begin
            delay <= 8'd10 + 8'(rnd() & 32'h7);
            boot();
            wr(`FMBC_REG_CTRL, 32'h1d);
            wr(`FMBC_REG_WDOG, 32'd40);
            if (k != 2) pulse(k);
            wait_load(300);
            chk("error load", 32'h1, {31'h0, seen});
            chk("error address", 32'h0, load_addr);
            chk("async read", 32'h0, {31'h0, sync_rd});
            chk("pins driven", 32'h1, {31'h0, rs_oe});
            chk("pins low", 32'h0, {30'h0, rs});
            rd(`FMBC_REG_HIST);
            chk("error history", 32'h1 << k, got);
            wait_load(100);
            chk("no watchdog", 32'h0, {31'h0, seen});
            pulse(1);
            wait_load(60);
            chk("no retry", 32'h0, {31'h0, seen});
            chk("halt init", 32'h0, {31'h0, init});
            chk("halt done", 32'h0, {31'h0, done});
            rd(`FMBC_REG_HIST);
            chk("halt history", 32'h82, got);
        end
        $display("error kinds test done");
        boot();
        wr(`FMBC_REG_WARM, 32'h0001_2340);
        pulse(6);
        rd(`FMBC_REG_WARM);
        chk("unset warm address", 32'h0, got);
        pulse(5);
        wait_load(200);
        wr(`FMBC_REG_CTRL, 32'h0);
        pulse(0);
        wait_load(60);
        chk("fallback off", 32'h0, {31'h0, seen});
        chk("fallback off init", 32'h0, {31'h0, init});
        $display("fallback disabled test done");
        summarize();
    end
endmodule
